// *** logic/adc_ctrl_pkg.sv ***
// Constants and types for the converter mode and output control block.
// Notes on behaviour
// - Reference select low means internal references; high means external references.
// - Both configuration pins low puts the converter into power-down.
// - Pins decode low-high mode 1, high-low mode 2, high-high mode 3.
// - Modes 1 and 3 unity gain, mode 2 half gain, mode 3 minus one volt.
// - Twelve result bits leave through buffers that the enable pin can tristate.
// - Output drive enable is active low; high disables the data buffers.
// - Output drive enable acts without waiting for any clock edge.
// - Each rising edge samples; its result appears after the fifth following edge.
// - Over-range flag rises with the result of an out-of-span sample.
// - Input is acquired during a window of one full clock period, every other period.
// - Results are unsigned straight binary on the twelve data outputs.
package adc_ctrl_pkg;
   localparam int RESULT_WIDTH = 12;
   localparam int LATENCY_CYCLES = 5;
   localparam int MAX_SAMPLE_MHZ = 15;
   localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
   localparam logic [1:0] CFG_POWER_DOWN = 2'h0;
   localparam logic [1:0] CFG_UNITY = 2'h1;
   localparam logic [1:0] CFG_HALF = 2'h2;
   localparam logic [1:0] CFG_OFFSET = 2'h3;
   typedef enum logic [3:0] {
      MODE_POWER_DOWN = 4'h1,
      MODE_UNITY = 4'h2,
      MODE_HALF = 4'h4,
      MODE_OFFSET = 4'h8
   } mode_e;
endpackage

// *** logic/adc_mode_and_output_control.sv ***
// Mode decode, result pipeline and output drive control of the sampling converter.
`timescale 1ns/1ps
`default_nettype none
module adc_mode_and_output_control (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Static configuration pins
   input wire logic cfg_pin_low,
   input wire logic cfg_pin_high,
   input wire logic ref_source_select,
   // Output drive enable, active low
   input wire logic out_enable_n,
   // Raw quantiser result and span comparison for the current sample
   input wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] sample_code,
   input wire logic sample_over_range,
   // Downstream ready for the buffered result stream
   input wire logic result_ready,
   // Analog front-end controls
   output logic power_down,
   output logic use_external_ref,
   output logic gain_half,
   output logic offset_minus_one,
   output logic sample_window,
   // Result pins
   output logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_data,
   output logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_data_oe,
   output logic over_range_pin,
   output logic over_range_pin_oe,
   // Buffered result stream
   output logic result_valid,
   output logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_word,
   output logic result_flag
);
   localparam int W = adc_ctrl_pkg::RESULT_WIDTH;
   localparam int L = adc_ctrl_pkg::LATENCY_CYCLES;

   logic [2:0] sync_low, sync_high, sync_ref;
   logic cfg_low, cfg_high;
   adc_ctrl_pkg::mode_e mode, next_mode;
   logic [W-1:0] pipe_code [L];
   logic [L-1:0] pipe_ovr;
   logic [L-1:0] pipe_live;
   logic [W-1:0] out_word;
   logic out_ovr;
   logic push, pop;
   logic spare_valid, spare_flag;
   logic [W-1:0] spare_word;

   // True while the decoded mode converts; power-down halts the front end.
   function automatic logic converting(input adc_ctrl_pkg::mode_e m);
      return m != adc_ctrl_pkg::MODE_POWER_DOWN;
   endfunction

   // The last two stages agree once a pin level has settled.
   function automatic logic settled(input logic [2:0] chain);
      return chain[2] == chain[1];
   endfunction

   // Static pins come from outside the domain and pass three flip-flops.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_low <= 3'h0;
         sync_high <= 3'h0;
         sync_ref <= 3'h0;
      end else begin
         sync_low <= {sync_low[1:0], cfg_pin_low};
         sync_high <= {sync_high[1:0], cfg_pin_high};
         sync_ref <= {sync_ref[1:0], ref_source_select};
      end
   end

   // Waiting for agreement keeps a pin caught mid-transition from flashing a
   // wrong mode for one cycle; a clean level change costs no extra cycle of settling.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_low <= 1'b0;
         cfg_high <= 1'b0;
      end else begin
         if (settled(sync_low)) begin
            cfg_low <= sync_low[2];
         end
         if (settled(sync_high)) begin
            cfg_high <= sync_high[2];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         use_external_ref <= 1'b0;
      end else if (settled(sync_ref)) begin
         use_external_ref <= sync_ref[2];
      end
   end

   always_comb begin
      case ({cfg_high, cfg_low})
         adc_ctrl_pkg::CFG_POWER_DOWN: next_mode = adc_ctrl_pkg::MODE_POWER_DOWN;
         adc_ctrl_pkg::CFG_UNITY: next_mode = adc_ctrl_pkg::MODE_UNITY;
         adc_ctrl_pkg::CFG_HALF: next_mode = adc_ctrl_pkg::MODE_HALF;
         adc_ctrl_pkg::CFG_OFFSET: next_mode = adc_ctrl_pkg::MODE_OFFSET;
         default: next_mode = adc_ctrl_pkg::MODE_POWER_DOWN;
      endcase
   end

   // Front-end steering follows the decoded mode; reset holds power-down.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode <= adc_ctrl_pkg::MODE_POWER_DOWN;
         power_down <= 1'b1;
         gain_half <= 1'b0;
         offset_minus_one <= 1'b0;
      end else begin
         mode <= next_mode;
         power_down <= !converting(next_mode);
         gain_half <= (next_mode == adc_ctrl_pkg::MODE_HALF);
         offset_minus_one <= (next_mode == adc_ctrl_pkg::MODE_OFFSET);
      end
   end

   // Acquisition toggles on each edge while converting, so it is high one full cycle in two.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_window <= 1'b0;
      end else begin
         sample_window <= converting(mode) && !sample_window;
      end
   end

   // Five-stage result pipeline; a stage is live only while converting, so words
   // taken before power-down exit never reach the stream.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < L; i++) begin
            pipe_code[i] <= adc_ctrl_pkg::RESULT_RESET;
         end
         pipe_ovr <= '0;
         pipe_live <= '0;
      end else begin
         pipe_code[0] <= sample_code;
         pipe_ovr[0] <= sample_over_range;
         pipe_live[0] <= converting(mode);
         for (int i = 1; i < L; i++) begin
            pipe_code[i] <= pipe_code[i-1];
            pipe_ovr[i] <= pipe_ovr[i-1];
            pipe_live[i] <= pipe_live[i-1] && converting(mode);
         end
      end
   end

   // Pin outputs: result after the fifth edge, flag in step with it.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_word <= adc_ctrl_pkg::RESULT_RESET;
         out_ovr <= 1'b0;
      end else begin
         out_word <= pipe_code[L-1];
         out_ovr <= pipe_ovr[L-1];
      end
   end

   // The drive enable must not wait for a clock, so it gates the registered
   // pin values combinationally; the enables are the only non-register outputs.
   assign result_data = out_word;
   assign over_range_pin = out_ovr;
   assign result_data_oe = {W{!out_enable_n}};
   assign over_range_pin_oe = !out_enable_n;

   // Two-entry buffer: a head register and a spare register. A one-cycle stall of
   // the receiver loses no word while the spare is empty. The converter itself cannot be paused, so a
   // stall longer than one cycle drops the newest words until room returns.
   // A word may still enter a full buffer in the cycle the head is taken.
   assign pop = result_valid && result_ready;
   assign push = pipe_live[L-1] && (!spare_valid || pop);

   // The head register drives the stream ports, so they come from flops.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_valid <= 1'b0;
         result_word <= adc_ctrl_pkg::RESULT_RESET;
         result_flag <= 1'b0;
      end else begin
         if (!result_valid || pop) begin
            if (spare_valid) begin
               result_valid <= 1'b1;
               result_word <= spare_word;
               result_flag <= spare_flag;
            end else if (push) begin
               result_valid <= 1'b1;
               result_word <= pipe_code[L-1];
               result_flag <= pipe_ovr[L-1];
            end else begin
               result_valid <= 1'b0;
            end
         end
      end
   end

   // The spare fills when a word arrives while the head is held, or refills
   // in the same cycle that the head takes the spare's old word.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         spare_valid <= 1'b0;
         spare_word <= adc_ctrl_pkg::RESULT_RESET;
         spare_flag <= 1'b0;
      end else begin
         if (push && (spare_valid || (result_valid && !pop))) begin
            spare_valid <= 1'b1;
            spare_word <= pipe_code[L-1];
            spare_flag <= pipe_ovr[L-1];
         end else if (pop) begin
            spare_valid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/adc_capture_model.sv ***
// Capture side model for the result stream.
`timescale 1ns/1ps
`default_nettype none
module adc_capture_model (
   input wire logic stall,
   input wire logic result_valid,
   output logic result_ready,
   output logic taken
);
   // Ready falls only when the bench asks, so every stall is deliberate.
   assign result_ready = !stall;
   assign taken = result_valid && result_ready;
endmodule
`default_nettype wire

// *** verif/adc_ctrl_chk.sv ***
// Port assertions for the converter control.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Configuration and drive enable pins
   input wire logic cfg_pin_low,
   input wire logic cfg_pin_high,
   input wire logic ref_source_select,
   input wire logic out_enable_n,
   // Sample inputs and stream ready
   input wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] sample_code,
   input wire logic sample_over_range,
   input wire logic result_ready,
   // Front-end controls
   input wire logic power_down,
   input wire logic use_external_ref,
   input wire logic gain_half,
   input wire logic offset_minus_one,
   input wire logic sample_window,
   // Result pins and stream
   input wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_data,
   input wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_data_oe,
   input wire logic over_range_pin,
   input wire logic over_range_pin_oe,
   input wire logic result_valid,
   input wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] result_word,
   input wire logic result_flag
);
   wire logic [1:0] cfg = {cfg_pin_high, cfg_pin_low};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_oe_tracks: assert property ({result_data_oe, over_range_pin_oe} == {13{!out_enable_n}})
      else $error("oe");
   a_ref_tracks: assert property ($stable(ref_source_select)[*7] |-> use_external_ref == ref_source_select)
      else $error("ref");
   a_mode_down: assert property ($stable(cfg)[*7] |-> power_down == (cfg == 2'h0)) else $error("pd");
   a_half_gain: assert property ($stable(cfg)[*7] |-> gain_half == (cfg == 2'h2)) else $error("gain");
   a_offset_set: assert property ($stable(cfg)[*7] |-> offset_minus_one == &cfg) else $error("offset");
   a_data_delay: assert property (!power_down[*8] |-> result_data == $past(sample_code, 6))
      else $error("data");
   a_flag_align: assert property (!power_down[*8] |-> over_range_pin == $past(sample_over_range, 6))
      else $error("flag");
   a_window_turn: assert property (!power_down[*2] |-> $changed(sample_window)) else $error("window");
   a_stall_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_word)
      && $stable(result_flag)) else $error("hold");
endmodule
bind adc_mode_and_output_control adc_ctrl_chk chk_u (.*);
`default_nettype wire

// *** verif/tb_adc_mode_and_output_control.sv ***
// Bench for the converter control.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_mode_and_output_control;
   logic sys_clk, reset_n, cfg_pin_low, cfg_pin_high, ref_source_select, out_enable_n, stall, taken;
   logic result_ready, power_down, use_external_ref, gain_half, offset_minus_one;
   logic sample_window, over_range_pin, over_range_pin_oe, result_valid, result_flag;
   logic sample_over_range = 1'b0;
   logic [11:0] sample_code = 12'h000;
   logic [11:0] result_data, result_data_oe, result_word, last, expect_data;
   int failures, num_checks, jumps;
   adc_mode_and_output_control dut_u (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .cfg_pin_low(cfg_pin_low),
      .cfg_pin_high(cfg_pin_high),
      .ref_source_select(ref_source_select),
      .out_enable_n(out_enable_n),
      .sample_code(sample_code),
      .sample_over_range(sample_over_range),
      .result_ready(result_ready),
      .power_down(power_down),
      .use_external_ref(use_external_ref),
      .gain_half(gain_half),
      .offset_minus_one(offset_minus_one),
      .sample_window(sample_window),
      .result_data(result_data),
      .result_data_oe(result_data_oe),
      .over_range_pin(over_range_pin),
      .over_range_pin_oe(over_range_pin_oe),
      .result_valid(result_valid),
      .result_word(result_word),
      .result_flag(result_flag)
   );
   adc_capture_model cap_u (
      .stall(stall),
      .result_valid(result_valid),
      .result_ready(result_ready),
      .taken(taken)
   );
   task automatic check(input string name, input logic [11:0] exp, input logic [11:0] seen);
      num_checks++;
      if (seen !== exp) failures++;
      if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // A counting input turns every lost word into a gap.
   always @(negedge sys_clk) {sample_over_range, sample_code} <= {~sample_code[0], sample_code + 12'h001};
   always @(posedge sys_clk) begin
      if (result_valid) check("flag", {11'h0, result_word[0]}, {11'h0, result_flag});
      if (taken) jumps += int'(result_word !== last + 12'h001);
      if (taken) last = result_word;
   end
   initial begin
      {reset_n, cfg_pin_low, cfg_pin_high, ref_source_select, out_enable_n, stall} = '0;
      repeat (3) @(negedge sys_clk);
      reset_n = 1'b1;
      #1 check("reset", 12'h008, {8'h0, power_down, gain_half, offset_minus_one, use_external_ref});
      check("drive", 12'hfff, result_data_oe);
      check("flag drive", 12'h001, {11'h0, over_range_pin_oe});
      @(negedge sys_clk) out_enable_n = 1'b1;
      #1 check("drive", 12'h000, result_data_oe);
      check("flag drive", 12'h000, {11'h0, over_range_pin_oe});
      $display("test drive done");
      for (int m = 0; m < 4; m++) begin
         @(negedge sys_clk) {cfg_pin_high, cfg_pin_low, ref_source_select} = {m[1:0], m[0]};
         repeat (8) @(negedge sys_clk);
         check("mode", {8'h0, m == 0, m == 2, m == 3, m[0]},
            {8'h0, power_down, gain_half, offset_minus_one, use_external_ref});
      end
      $display("test modes done");
      repeat (20) @(negedge sys_clk);
      expect_data = sample_code - 12'(adc_ctrl_pkg::LATENCY_CYCLES);
      check("data", expect_data, result_data);
      check("range", {11'h0, expect_data[0]}, {11'h0, over_range_pin});
      stall = 1'b1;
      repeat (10) @(negedge sys_clk);
      stall = 1'b0;
      repeat (20) @(negedge sys_clk);
      check("gaps", 12'h002, 12'(jumps));
      $display("test stream done");
      wrap_up;
   end
   initial begin
      #5000 failures++;
      wrap_up;
   end
endmodule
`default_nettype wire
